// File: core/cebs_pkg.sv
/*
  constants and types of the execution and bus-sizing core.
  assumes byte-addressed apb and a 24-bit memory address.
*/
package cebs_pkg;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_OPA = 8'h04;
  localparam logic [7:0] REG_OPB = 8'h08;
  localparam logic [7:0] REG_RES = 8'h0c;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_STACK = 8'h14;
  localparam logic [7:0] REG_STAT = 8'h18;
  localparam logic [7:0] REG_CTRL = 8'h1c;
  localparam logic [7:0] REG_AREA = 8'h20;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SZ_LSB = 8;
  localparam int CMD_CC_BIT = 12;
  localparam int CMD_CNT_LSB = 16;
  localparam int SW_CARRY_BIT = 0;
  localparam int SW_MASK_LSB = 12;
  localparam int SW_MAX_BIT = 15;
  localparam int STAT_ACC_LSB = 16;
  localparam int STAT_BANK_LSB = 24;
  localparam int STAT_EMPTY_BIT = 29;
  localparam int STAT_BUSY_BIT = 31;
  localparam logic [2:0] MASK_ALL = 3'h7;
  localparam logic [2:0] MASK_RST = 3'h7;
  localparam logic [31:0] TRAP_BASE = 32'h0000_8000;
  localparam logic [31:0] TRAP_STEP = 32'h0000_0010;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [31:0] STACK_RST = 32'h0000_0000;
  localparam logic [3:0] AREA_RST = 4'hf;
  localparam logic [23:0] IO_END = 24'h00_1000;
  localparam logic [23:0] IRAM_END = 24'h00_8000;
  localparam logic [4:0] SHIFT_ZERO_CNT = 5'h10;

  typedef enum logic [4:0] {
    op_nop, first_set_bit_from_lsb, first_set_bit_from_msb, wide_mode,
    interrupt_unmask_level, interrupt_mask_all, software_trap,
    control_reg_move, control_reg_fetch, frame_create, frame_release,
    bank_pointer_load, bank_pointer_step_up, bank_pointer_step_down,
    rotate_left_circular, rotate_right_circular, rotate_left_via_flag,
    rotate_right_via_flag, shift_left_arith, shift_right_arith,
    shift_left_zero_fill, shift_right_zero_fill, decrement_branch_nonzero,
    interrupt_return, short_relative_jump, long_relative_jump,
    op_push, op_pop, op_load, op_store
  } cebs_op_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_SHIFT, ST_T1, ST_WAIT, ST_T2
  } cebs_st_t;

  typedef struct packed {
    logic clk_out;
    logic ale;
    logic rd;
    logic wr_lo;
    logic wr_hi;
    logic oe_lo;
    logic oe_hi;
    logic [23:0] addr;
    logic [15:0] dout;
  } cebs_bus_t;

  typedef struct packed {
    cebs_st_t st;
    cebs_op_t op;
    logic [1:0] sz;
    logic cc;
    logic [4:0] cnt;
    logic [1:0] phase;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] res;
    logic [31:0] pc;
    logic [31:0] system_stack_pointer;
    logic [31:0] ctrl;
    logic [3:0] area;
    logic [7:0] acc;
    logic carry_flag;
    logic [2:0] interrupt_mask_field;
    logic max_mode;
    logic [2:0] bank_select_pointer;
    logic empty;
    logic [23:0] xa;
    logic [31:0] xd;
    logic [2:0] xn;
    logic [1:0] xi;
    logic xw;
    cebs_bus_t bus;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cebs_state_t;
endpackage : cebs_pkg

// File: core/cebs_core.sv
/*
  execution core for control, bank, frame, branch, rotate/shift and
  bit-search operations, with a dynamically sized 8/16-bit memory bus.
  assumes apb commands and synchronous memory inputs.
*/
// The placing of the registers and the APB register port were left to the implementer.
//
// Function
// RULE1: forward search finds lowest set bit, backward the highest; index to A.
// RULE2: wide mode sets maximum mode, with a 32-bit pc.
// RULE3: mask-all sets interrupt mask to 7; unmask loads it from immediate.
// RULE4: trap pushes pc then status word, jumps to 8000h plus 10h times imm.
// RULE5: control move copies general register to control register or back.
// RULE6: frame create pushes register, loads it with sp, adds displacement.
// RULE7: bank pointer loads immediate, steps up by one, steps down by one.
// RULE8: circular rotates wrap bit to other end and copy it into carry.
// RULE9: shifts fill zero, arithmetic right keeps msb, last bit out to carry.
// RULE10: decrement counter; branch by 8-bit offset only if nonzero.
// RULE11: interrupt return pops status word and pc from the stack.
// RULE12: relative jumps add 8 or 16-bit offset when condition holds.
// RULE13: word and long operands allowed at any byte address.
// RULE14: push decrements sp first, then stores lsb at lowest address.
// RULE15: width chosen per cycle; operands split into needed cycles.
// RULE16: per-area width setting decides each cycle's external width.
// RULE17: long at even address on 16-bit memory uses two full cycles.
// RULE18: long at odd address uses upper lane, both lanes, then lower lane.
// RULE19: 8-bit memory uses low lane only; odd byte on 16-bit uses upper.
// RULE20: unused lane ignored on reads, undriven and unstrobed on writes.
// RULE21: internal memory 16-bit zero wait; built-in i/o 8-bit.
// RULE22: i/o cycle gets one wait when clock output is high at ale.
`timescale 1ns/10ps
`default_nettype none

module cebs_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output var cebs_pkg::cebs_bus_t bus_out,
  input wire logic [15:0] bus_din,
  input wire logic bus_wait
);

  cebs_pkg::cebs_state_t r;
  cebs_pkg::cebs_state_t nx;
  logic [3:0] pl;
  logic [3:0] pn;
  logic [5:0] hit;
  logic [32:0] sh;
  logic [31:0] nb;
  logic [31:0] cnt_new;
  logic [31:0] rd_word;
  logic [1:0] i1;
  logic setup;
  logic wen;
  logic mapped;
  logic t2w;
  logic [7:0] b0;
  logic [7:0] b1;

  function automatic logic [2:0] f_bytes(logic [1:0] sz);
    return (sz == 2'h0) ? 3'h1 : (sz == 2'h1) ? 3'h2 : 3'h4;
  endfunction : f_bytes

  function automatic logic [4:0] f_msb(logic [1:0] sz);
    return (sz == 2'h0) ? 5'h07 : (sz == 2'h1) ? 5'h0f : 5'h1f;
  endfunction : f_msb

  function automatic logic [31:0] f_trim(logic [31:0] v, logic [1:0] sz);
    return (sz == 2'h0) ? {24'h0, v[7:0]} :
           (sz == 2'h1) ? {16'h0, v[15:0]} : v;
  endfunction : f_trim

  function automatic logic [31:0] f_sext8(logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction : f_sext8

  function automatic logic [31:0] f_sext16(logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : f_sext16

  // {found, index}; the last hit wins
  function automatic logic [5:0] f_search(logic [15:0] v, logic fwd);
    logic [5:0] h;
    h = 6'h00;
    for (int i = 0; i < 16; i++) begin
      if (fwd && v[15 - i]) h = {1'b1, 5'(15 - i)};
      if (!fwd && v[i]) h = {1'b1, 5'(i)};
    end
    return h;
  endfunction : f_search

  // one rotate/shift step: {bit out, value}
  function automatic logic [32:0] f_shift1(cebs_pkg::cebs_op_t o,
      logic [1:0] sz, logic [31:0] v, logic c);
    logic [4:0] mi;
    logic left;
    logic inb;
    logic [31:0] w;
    mi = f_msb(sz);
    left = o inside {cebs_pkg::rotate_left_circular,
                     cebs_pkg::rotate_left_via_flag,
                     cebs_pkg::shift_left_arith,
                     cebs_pkg::shift_left_zero_fill};
    case (o)
      cebs_pkg::rotate_left_circular: inb = v[mi]; // see RULE8
      cebs_pkg::rotate_right_circular: inb = v[0]; // see RULE8
      cebs_pkg::rotate_left_via_flag,
      cebs_pkg::rotate_right_via_flag: inb = c; // see RULE8
      cebs_pkg::shift_right_arith: inb = v[mi]; // see RULE9
      default: inb = 1'b0; // see RULE9
    endcase
    if (left) begin
      w = {v[30:0], inb};
    end else begin
      w = v >> 1;
      w[mi] = inb;
    end
    return {left ? v[mi] : v[0], f_trim(w, sz)}; // see RULE8 RULE9
  endfunction : f_shift1

  // {i/o, internal, both lanes, upper only} of one cycle
  function automatic logic [3:0] f_plan(logic [23:0] a, logic [2:0] n,
      logic [3:0] area);
    logic io;
    logic im;
    logic w16;
    io = a < cebs_pkg::IO_END; // see RULE21
    im = !io && (a < cebs_pkg::IRAM_END); // see RULE21
    w16 = im || (!io && area[a[23:22]]); // see RULE15 RULE16
    return {io, im, w16 && !a[0] && (n > 3'h1), w16 && a[0]}; // see RULE17 RULE18 RULE19
  endfunction : f_plan

  function automatic logic [15:0] f_sw(cebs_pkg::cebs_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[cebs_pkg::SW_CARRY_BIT] = s.carry_flag;
    w[cebs_pkg::SW_MASK_LSB +: 3] = s.interrupt_mask_field;
    w[cebs_pkg::SW_MAX_BIT] = s.max_mode;
    return w;
  endfunction : f_sw

  function automatic cebs_pkg::cebs_state_t f_load_sw(
      cebs_pkg::cebs_state_t s, logic [15:0] w);
    s.carry_flag = w[cebs_pkg::SW_CARRY_BIT];
    s.interrupt_mask_field = w[cebs_pkg::SW_MASK_LSB +: 3];
    s.max_mode = w[cebs_pkg::SW_MAX_BIT];
    return s;
  endfunction : f_load_sw

  function automatic logic [31:0] f_status(cebs_pkg::cebs_state_t s);
    logic [31:0] w;
    w = 32'h0;
    w[15:0] = f_sw(s);
    w[cebs_pkg::STAT_ACC_LSB +: 8] = s.acc;
    w[cebs_pkg::STAT_BANK_LSB +: 3] = s.bank_select_pointer;
    w[cebs_pkg::STAT_EMPTY_BIT] = s.empty;
    w[cebs_pkg::STAT_BUSY_BIT] = s.st != cebs_pkg::ST_IDLE;
    return w;
  endfunction : f_status

  // start an n-byte transfer, lsb first
  function automatic cebs_pkg::cebs_state_t f_go(cebs_pkg::cebs_state_t s,
      logic [31:0] a, logic [31:0] d, logic [2:0] n, logic w);
    s.xa = a[23:0];
    s.xd = d;
    s.xn = n;
    s.xi = 2'h0;
    s.xw = w;
    s.st = cebs_pkg::ST_T1;
    return s;
  endfunction : f_go

  always_comb begin
    nx = r;
    pl = f_plan(r.xa, r.xn, r.area);
    hit = 6'h00;
    sh = 33'h0;
    cnt_new = 32'h0;
    rd_word = 32'h0;
    mapped = 1'b1;
    i1 = r.xi + 2'h1;
    nb = {29'h0, f_bytes(r.sz)};
    setup = psel && !penable;
    wen = psel && penable && r.pready && pwrite && !r.pslverr &&
          (r.st == cebs_pkg::ST_IDLE);

    case (paddr)
      cebs_pkg::REG_CMD: rd_word = 32'h0;
      cebs_pkg::REG_OPA: rd_word = r.opa;
      cebs_pkg::REG_OPB: rd_word = r.opb;
      cebs_pkg::REG_RES: rd_word = r.res;
      cebs_pkg::REG_PC: rd_word = r.pc;
      cebs_pkg::REG_STACK: rd_word = r.system_stack_pointer;
      cebs_pkg::REG_STAT: rd_word = f_status(r);
      cebs_pkg::REG_CTRL: rd_word = r.ctrl;
      cebs_pkg::REG_AREA: rd_word = {28'h0, r.area};
      default: mapped = 1'b0;
    endcase
    // pready one cycle after setup, always a flop
    nx.pready = setup;
    nx.pslverr = setup && !mapped;
    if (setup && !pwrite) nx.prdata = rd_word;

    // writes land only while idle, so none races an operation
    if (wen) begin
      case (paddr)
        cebs_pkg::REG_CMD: begin
          nx.op = cebs_pkg::cebs_op_t'(pwdata[cebs_pkg::CMD_OP_LSB +: 5]);
          nx.sz = pwdata[cebs_pkg::CMD_SZ_LSB +: 2];
          nx.cc = pwdata[cebs_pkg::CMD_CC_BIT];
          nx.cnt = pwdata[cebs_pkg::CMD_CNT_LSB +: 5];
          nx.phase = 2'h0;
          nx.st = cebs_pkg::ST_EXEC;
        end
        cebs_pkg::REG_OPA: nx.opa = pwdata;
        cebs_pkg::REG_OPB: nx.opb = pwdata;
        cebs_pkg::REG_PC: nx.pc = pwdata;
        cebs_pkg::REG_STACK: nx.system_stack_pointer = pwdata;
        cebs_pkg::REG_STAT: begin
          nx = f_load_sw(nx, pwdata[15:0]);
          nx.bank_select_pointer = pwdata[cebs_pkg::STAT_BANK_LSB +: 3];
        end
        cebs_pkg::REG_CTRL: nx.ctrl = pwdata;
        cebs_pkg::REG_AREA: nx.area = pwdata[3:0];
        default: ;
      endcase
    end

    unique case (r.st)
      cebs_pkg::ST_IDLE: ;
      cebs_pkg::ST_EXEC: begin
        nx.st = cebs_pkg::ST_IDLE;
        case (r.op)
          cebs_pkg::op_nop: ;
          cebs_pkg::first_set_bit_from_lsb,
          cebs_pkg::first_set_bit_from_msb: begin
            hit = f_search(r.opb[15:0],
                           r.op == cebs_pkg::first_set_bit_from_lsb);
            if (hit[5]) nx.acc = {3'h0, hit[4:0]}; // see RULE1
            nx.empty = !hit[5];
          end
          cebs_pkg::wide_mode: nx.max_mode = 1'b1; // see RULE2
          cebs_pkg::interrupt_unmask_level:
            nx.interrupt_mask_field = r.opa[2:0]; // see RULE3
          cebs_pkg::interrupt_mask_all:
            nx.interrupt_mask_field = cebs_pkg::MASK_ALL; // see RULE3
          cebs_pkg::software_trap: begin
            if (r.phase == 2'h0) begin
              nx.system_stack_pointer = r.system_stack_pointer - 32'h4;
              nx = f_go(nx, nx.system_stack_pointer, r.pc, 3'h4, 1'b1); // see RULE4
            end else if (r.phase == 2'h1) begin
              nx.system_stack_pointer = r.system_stack_pointer - 32'h2;
              nx = f_go(nx, nx.system_stack_pointer, {16'h0, f_sw(r)},
                        3'h2, 1'b1); // see RULE4
            end else begin
              nx.pc = cebs_pkg::TRAP_BASE +
                      32'(cebs_pkg::TRAP_STEP * {29'h0, r.opa[2:0]}); // see RULE4
            end
          end
          cebs_pkg::control_reg_move: nx.ctrl = r.opb; // see RULE5
          cebs_pkg::control_reg_fetch: begin
            nx.opb = r.ctrl; // see RULE5
            nx.res = r.ctrl;
          end
          cebs_pkg::frame_create: begin
            if (r.phase == 2'h0) begin
              nx.system_stack_pointer = r.system_stack_pointer - 32'h4;
              nx = f_go(nx, nx.system_stack_pointer, r.opb, 3'h4, 1'b1); // see RULE6
            end else begin
              nx.opb = r.system_stack_pointer; // see RULE6
              nx.system_stack_pointer = r.system_stack_pointer +
                                        f_sext16(r.opa[15:0]);
            end
          end
          cebs_pkg::frame_release: begin
            if (r.phase == 2'h0) begin
              nx.system_stack_pointer = r.opb; // see RULE6
              nx = f_go(nx, r.opb, 32'h0, 3'h4, 1'b0);
            end else begin
              nx.opb = r.xd; // see RULE6
              nx.system_stack_pointer = r.system_stack_pointer + 32'h4;
            end
          end
          cebs_pkg::bank_pointer_load:
            nx.bank_select_pointer = r.opa[2:0]; // see RULE7
          cebs_pkg::bank_pointer_step_up:
            nx.bank_select_pointer = r.bank_select_pointer + 3'h1; // see RULE7
          cebs_pkg::bank_pointer_step_down:
            nx.bank_select_pointer = r.bank_select_pointer - 3'h1; // see RULE7
          cebs_pkg::rotate_left_circular, cebs_pkg::rotate_right_circular,
          cebs_pkg::rotate_left_via_flag, cebs_pkg::rotate_right_via_flag,
          cebs_pkg::shift_left_arith, cebs_pkg::shift_right_arith,
          cebs_pkg::shift_left_zero_fill, cebs_pkg::shift_right_zero_fill:
          begin
            // one bit a cycle keeps the shifter one small mux
            nx.res = f_trim(r.opb, r.sz);
            nx.cnt = (r.cnt == 5'h0) ? cebs_pkg::SHIFT_ZERO_CNT : r.cnt;
            nx.st = cebs_pkg::ST_SHIFT;
          end
          cebs_pkg::decrement_branch_nonzero: begin
            cnt_new = f_trim(r.opb - 32'h1, r.sz); // see RULE10
            nx.opb = cnt_new;
            if (cnt_new != 32'h0) nx.pc = r.pc + f_sext8(r.opa[7:0]); // see RULE10
          end
          cebs_pkg::interrupt_return: begin
            if (r.phase == 2'h0) begin
              nx = f_go(nx, r.system_stack_pointer, 32'h0, 3'h2, 1'b0); // see RULE11
            end else if (r.phase == 2'h1) begin
              nx = f_load_sw(nx, r.xd[15:0]); // see RULE11
              nx.system_stack_pointer = r.system_stack_pointer + 32'h2;
              nx = f_go(nx, nx.system_stack_pointer, 32'h0, 3'h4, 1'b0);
            end else begin
              nx.pc = r.xd; // see RULE11
              nx.system_stack_pointer = r.system_stack_pointer + 32'h4;
            end
          end
          cebs_pkg::short_relative_jump:
            if (r.cc) nx.pc = r.pc + f_sext8(r.opa[7:0]); // see RULE12
          cebs_pkg::long_relative_jump:
            if (r.cc) nx.pc = r.pc + f_sext16(r.opa[15:0]); // see RULE12
          cebs_pkg::op_push: begin
            if (r.phase == 2'h0) begin
              nx.system_stack_pointer = r.system_stack_pointer - nb; // see RULE14
              nx = f_go(nx, nx.system_stack_pointer, f_trim(r.opb, r.sz),
                        f_bytes(r.sz), 1'b1); // see RULE14
            end
          end
          cebs_pkg::op_pop: begin
            if (r.phase == 2'h0) begin
              nx = f_go(nx, r.system_stack_pointer, 32'h0, f_bytes(r.sz), 1'b0);
            end else begin
              nx.res = r.xd;
              nx.system_stack_pointer = r.system_stack_pointer + nb;
            end
          end
          // any byte address, no alignment check
          cebs_pkg::op_load: begin
            if (r.phase == 2'h0)
              nx = f_go(nx, r.opa, 32'h0, f_bytes(r.sz), 1'b0); // see RULE13
            else
              nx.res = r.xd;
          end
          cebs_pkg::op_store: begin
            if (r.phase == 2'h0)
              nx = f_go(nx, r.opa, f_trim(r.opb, r.sz), f_bytes(r.sz),
                        1'b1); // see RULE13
          end
          default: ;
        endcase
      end
      cebs_pkg::ST_SHIFT: begin
        sh = f_shift1(r.op, r.sz, r.res, r.carry_flag);
        nx.res = sh[31:0];
        nx.carry_flag = sh[32]; // see RULE8 RULE9
        nx.cnt = r.cnt - 5'h1;
        if (r.cnt == 5'h1) nx.st = cebs_pkg::ST_IDLE;
      end
      cebs_pkg::ST_T1: begin
        if (pl[3] && r.bus.clk_out) nx.st = cebs_pkg::ST_WAIT; // see RULE22
        else nx.st = cebs_pkg::ST_T2;
      end
      cebs_pkg::ST_WAIT: nx.st = cebs_pkg::ST_T2;
      cebs_pkg::ST_T2: begin
        // only the external bus obeys bus_wait
        if (pl[3] || pl[2] || !bus_wait) begin // see RULE21
          if (!r.xw) begin
            nx.xd[{r.xi, 3'h0} +: 8] = pl[0] ? bus_din[15:8] : bus_din[7:0]; // see RULE19 RULE20
            if (pl[1]) nx.xd[{i1, 3'h0} +: 8] = bus_din[15:8]; // see RULE17
          end
          nx.xa = r.xa + (pl[1] ? 24'h2 : 24'h1); // see RULE15
          nx.xi = r.xi + (pl[1] ? 2'h2 : 2'h1);
          nx.xn = r.xn - (pl[1] ? 3'h2 : 3'h1);
          if (nx.xn == 3'h0) begin
            nx.st = cebs_pkg::ST_EXEC;
            nx.phase = r.phase + 2'h1;
          end else begin
            nx.st = cebs_pkg::ST_T1;
          end
        end
      end
      default: nx.st = cebs_pkg::ST_IDLE;
    endcase

    if (!nx.max_mode) nx.pc[31:16] = 16'h0000; // see RULE2

    // pins follow the next state, so each is a flop
    pn = f_plan(nx.xa, nx.xn, nx.area);
    t2w = (nx.st == cebs_pkg::ST_T2) && nx.xw;
    b0 = nx.xd[{nx.xi, 3'h0} +: 8];
    b1 = nx.xd[{nx.xi + 2'h1, 3'h0} +: 8];
    nx.bus.clk_out = !r.bus.clk_out;
    nx.bus.ale = nx.st == cebs_pkg::ST_T1;
    nx.bus.addr = nx.xa;
    nx.bus.rd = (nx.st == cebs_pkg::ST_T2) && !nx.xw;
    nx.bus.wr_lo = t2w && !pn[0]; // see RULE20
    nx.bus.wr_hi = t2w && (pn[0] || pn[1]); // see RULE20
    nx.bus.oe_lo = t2w && !pn[0]; // see RULE20
    nx.bus.oe_hi = t2w && (pn[0] || pn[1]); // see RULE20
    nx.bus.dout = pn[0] ? {b0, 8'h00} : {pn[1] ? b1 : 8'h00, b0}; // see RULE18 RULE19
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.pc <= cebs_pkg::PC_RST;
      r.system_stack_pointer <= cebs_pkg::STACK_RST;
      r.area <= cebs_pkg::AREA_RST;
      r.interrupt_mask_field <= cebs_pkg::MASK_RST;
    end else begin
      r <= nx;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign bus_out = r.bus;

endmodule : cebs_core

`default_nettype wire

// File: testbench/cebs_core_checker.sv
/* bus assertions for cebs_core, bound at the foot.
   assumes registered bus_out fields. */
`timescale 1ns/10ps
`default_nettype none
module cebs_core_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire cebs_pkg::cebs_bus_t bus_out
);
  logic s;
  logic io;
  logic iram;
  assign s = bus_out.rd | bus_out.wr_lo | bus_out.wr_hi;
  assign io = bus_out.addr < cebs_pkg::IO_END;
  assign iram = !io && bus_out.addr < cebs_pkg::IRAM_END;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_oe;
    bus_out.oe_lo == bus_out.wr_lo && bus_out.oe_hi == bus_out.wr_hi;
  endproperty
  a_oe: assert property (p_oe)
    else $error("oe/strobe");
  property p_io_lo;
    s && io |-> !bus_out.wr_hi && !bus_out.oe_hi;
  endproperty
  a_io_lo: assert property (p_io_lo)
    else $error("io upper lane");
  property p_odd_hi;
    (bus_out.wr_lo | bus_out.wr_hi) && iram && bus_out.addr[0]
      |-> bus_out.wr_hi && !bus_out.wr_lo;
  endproperty
  a_odd_hi: assert property (p_odd_hi)
    else $error("odd lane");
  property p_two_even;
    bus_out.wr_lo && bus_out.wr_hi |-> !bus_out.addr[0];
  endproperty
  a_two_even: assert property (p_two_even)
    else $error("odd pair");
  property p_io_wait;
    bus_out.ale && io |->
      if (bus_out.clk_out) ##1 !s ##1 s else ##1 s;
  endproperty
  a_io_wait: assert property (p_io_wait)
    else $error("io wait");
  property p_iram_fast;
    bus_out.ale && iram |=> s;
  endproperty
  a_iram_fast: assert property (p_iram_fast)
    else $error("iram wait");
  property p_ale_one;
    bus_out.ale |=> !bus_out.ale;
  endproperty
  a_ale_one: assert property (p_ale_one)
    else $error("ale length");
  property p_addr_hold;
    s |-> $stable(bus_out.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("addr moved");
  property p_clk_half;
    $past(presetn) |-> $changed(bus_out.clk_out);
  endproperty
  a_clk_half: assert property (p_clk_half)
    else $error("clk_out stuck");
endmodule : cebs_core_checker
bind cebs_core cebs_core_checker i_chk (.pclk(pclk), .presetn(presetn),
  .bus_out(bus_out));
`default_nettype wire

// File: testbench/cebs_mem_model.sv
/* external 8/16-bit memory per area, 64 bytes deep.
   assumes wide_map matches the core's area register. */
`timescale 1ns/10ps
`default_nettype none
module cebs_mem_model (
  input wire logic pclk,
  input wire cebs_pkg::cebs_bus_t bus_out,
  input wire logic [3:0] wide_map,
  input wire logic slow,
  output logic [15:0] bus_din,
  output logic bus_wait
);
  logic [7:0] mem [64];
  logic [15:0] last = 16'h5a5a;
  logic seen = 1'b0;
  logic ext;
  logic wide;
  logic t2;
  logic [5:0] a;
  assign a = bus_out.addr[5:0];
  assign ext = bus_out.addr >= cebs_pkg::IRAM_END;
  assign wide = bus_out.addr >= cebs_pkg::IO_END &&
    (!ext || wide_map[bus_out.addr[23:22]]);
  assign t2 = bus_out.rd | bus_out.wr_lo | bus_out.wr_hi;
  assign bus_wait = slow & ext & t2 & ~seen;
  // idle lanes show the inverse of the last value
  always_comb begin
    if (!bus_out.rd) bus_din = ~last;
    else if (wide) bus_din = {mem[a | 6'h1], mem[a & 6'h3e]};
    else bus_din = {~last[15:8], mem[a]};
  end
  always_ff @(posedge pclk) begin
    last <= bus_din;
    seen <= t2;
    if (t2 && !bus_wait) begin
      if (wide && bus_out.wr_lo) mem[a & 6'h3e] <= bus_out.dout[7:0];
      if (wide && bus_out.wr_hi) mem[a | 6'h1] <= bus_out.dout[15:8];
      if (!wide && bus_out.wr_lo) mem[a] <= bus_out.dout[7:0];
    end
  end
endmodule : cebs_mem_model
`default_nettype wire

// File: testbench/cpu_exec_and_bus_sizing_tb.sv
/* self-checking bench for cebs_core and the memory model.
   assumes busy in STAT bit 31. */
`timescale 1ns/10ps
`default_nettype none
module cpu_exec_and_bus_sizing_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, bus_wait, slow = 0;
  logic [15:0] bus_din;
  cebs_pkg::cebs_bus_t bus_out;
  int failures = 0, num_checks = 0, k;
  typedef struct {logic [31:0] c, a, b; logic [7:0] r; logic [31:0] e;}
    cebs_row_t;
  cebs_row_t rows [24];
  logic [31:0] ads [4] = '{32'h40_0011, 32'h80_0021, 32'h105, 32'h1031};
  cebs_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_out(bus_out), .bus_din(bus_din), .bus_wait(bus_wait));
  cebs_mem_model i_mem (.pclk(pclk), .bus_out(bus_out), .wide_map(4'h2),
    .slow(slow), .bus_din(bus_din), .bus_wait(bus_wait));
  initial begin
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] c(input cebs_pkg::cebs_op_t o,
    input logic [4:0] n = 5'h1, input logic cc = 1'b0);
    return {11'h0, n, 3'h0, cc, 4'h2, 3'h0, o};
  endfunction : c
  task automatic report_and_stop;
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] e, g, input string n);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin failures++; report_and_stop(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic idle_wait;
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, cebs_pkg::REG_STAT, 32'h0);
      if (rd[31] === 1'b0) return;
    end
    failures++;
    report_and_stop();
  endtask : idle_wait
  task automatic run(input logic [31:0] cm, a, b);
    apb(1'b1, cebs_pkg::REG_OPA, a);
    apb(1'b1, cebs_pkg::REG_OPB, b);
    apb(1'b1, cebs_pkg::REG_CMD, cm);
    idle_wait();
  endtask : run
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, cebs_pkg::REG_PC, 32'h0); chk(32'h0, rd, "pc");
    apb(1'b0, cebs_pkg::REG_AREA, 32'h0); chk(32'hf, rd, "area");
    apb(1'b0, cebs_pkg::REG_STAT, 32'h0); chk(32'h7000, rd, "stat");
    apb(1'b0, 8'h40, 32'h0); chk({31'h0, err}, 32'h1, "slverr");
    apb(1'b1, cebs_pkg::REG_AREA, 32'h2);
    apb(1'b1, cebs_pkg::REG_STACK, 32'h40_0100);
    rows = '{
      '{c(cebs_pkg::first_set_bit_from_lsb), 0, 32'h50, 8'h18, 32'h4_7000},
      '{c(cebs_pkg::first_set_bit_from_msb), 0, 32'h50, 8'h18, 32'h6_7000},
      '{c(cebs_pkg::interrupt_unmask_level), 3, 0, 8'h18, 32'h6_3000},
      '{c(cebs_pkg::interrupt_mask_all), 0, 0, 8'h18, 32'h6_7000},
      '{c(cebs_pkg::bank_pointer_load), 5, 0, 8'h18, 32'h506_7000},
      '{c(cebs_pkg::bank_pointer_step_up), 0, 0, 8'h18, 32'h606_7000},
      '{c(cebs_pkg::bank_pointer_step_down), 0, 0, 8'h18, 32'h506_7000},
      '{c(cebs_pkg::wide_mode), 0, 0, 8'h18, 32'h506_f000},
      '{c(cebs_pkg::control_reg_move), 0, 32'h12345678, 8'h1c, 32'h12345678},
      '{c(cebs_pkg::control_reg_fetch), 0, 0, 8'h0c, 32'h12345678},
      '{c(cebs_pkg::rotate_left_circular), 0, 32'h80000001, 8'h0c, 32'h3},
      '{c(cebs_pkg::rotate_right_via_flag), 0, 0, 8'h0c, 32'h80000000},
      '{c(cebs_pkg::shift_right_arith), 0, 32'h80000002, 8'h0c, 32'hc0000001},
      '{c(cebs_pkg::shift_right_zero_fill), 0, 32'h80000001, 8'h18,
        32'h506_f001},
      '{c(cebs_pkg::decrement_branch_nonzero), 32'h10, 2, 8'h10, 32'h10},
      '{c(cebs_pkg::decrement_branch_nonzero), 32'h10, 1, 8'h10, 32'h10},
      '{c(cebs_pkg::short_relative_jump, 1, 1), 32'hf0, 0, 8'h10, 0},
      '{c(cebs_pkg::long_relative_jump, 1, 1), 32'h11234, 0, 8'h10, 32'h1234},
      '{c(cebs_pkg::software_trap), 3, 0, 8'h10, 32'h8030},
      '{c(cebs_pkg::interrupt_return), 0, 0, 8'h10, 32'h1234},
      '{c(cebs_pkg::frame_create), 32'hfffffff0, 32'haabbccdd, 8'h14,
        32'h40_00ec},
      '{c(cebs_pkg::frame_release), 0, 32'h40_00fc, 8'h08, 32'haabbccdd},
      '{c(cebs_pkg::op_push), 0, 32'h55aa, 8'h14, 32'h40_00fc},
      '{c(cebs_pkg::op_pop), 0, 0, 8'h0c, 32'h55aa}};
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].a, rows[i].b);
      apb(1'b0, rows[i].r, 32'h0);
      chk(rows[i].e, rd, $sformatf("row%0d", i));
    end
    slow = 1'b1;
    foreach (ads[i]) begin
      run(c(cebs_pkg::op_store), ads[i], 32'h4433_2211);
      for (k = 0; k < 4; k++)
        chk(8'h11 * (k + 1), i_mem.mem[6'(ads[i] + k)], "mem");
      run(c(cebs_pkg::op_load), ads[i], 32'h0);
      apb(1'b0, cebs_pkg::REG_RES, 32'h0);
      chk(32'h4433_2211, rd, "load");
    end
    apb(1'b1, cebs_pkg::REG_OPB, 32'h1);
    apb(1'b1, cebs_pkg::REG_CMD, c(cebs_pkg::shift_left_zero_fill, 5'h0));
    apb(1'b1, cebs_pkg::REG_OPB, 32'h5);
    idle_wait();
    apb(1'b0, cebs_pkg::REG_OPB, 32'h0); chk(32'h1, rd, "busy write");
    apb(1'b0, cebs_pkg::REG_RES, 32'h0); chk(32'h1_0000, rd, "sll");
    report_and_stop();
  end
endmodule : cpu_exec_and_bus_sizing_tb
`default_nettype wire
